// [hw/can_message_fifo_ctrl_status.sv]
`timescale 1ns/10ps
module can_message_fifo_ctrl_status (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic config_mode,
  input wire fifo_ctrl_pkg::reg_req_s reg_req,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [31:0] rx_timestamp,
  output logic ram_valid,
  input wire logic ram_ready,
  output fifo_ctrl_pkg::ram_word_s ram_word,
  input wire fifo_ctrl_pkg::tx_event_s tx_ev,
  output logic tx_pending,
  output logic [fifo_ctrl_pkg::DEPTH_W-1:0] tx_slot,
  output logic abort_request,
  output logic irq
);
  import fifo_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // State and derived signals
  // ----------------------------------------------------------------
  state_s s_reg; // Registered state
  state_s s_next; // Next state
  logic [COUNT_W-1:0] depth; // Slots configured, 1 to 32
  logic is_empty; // No message held
  logic is_full; // Every slot held
  logic half_low; // Occupancy at most half
  logic half_high; // Occupancy at least half
  logic [IE_W-1:0] flags; // Visible flag set, bits 4:0
  logic [31:0] control_word; // Control read image
  logic [31:0] status_word; // Status read image
  logic wr_ctl; // Write to control word
  logic wr_sta; // Write to status word
  logic cmd_lane; // Command byte written
  logic low_lane; // Low byte written
  logic adv; // Pointer advance written
  logic sw_set; // Software sets send request
  logic sw_abort; // Software clears a set request
  logic rtr_set; // Remote request triggers send
  logic push_tx; // Software commits a message
  logic pop_rx; // Software releases a message
  logic rx_fire; // Engine hands a message over
  logic rx_store; // Handed message has a slot
  logic rx_lost; // Handed message finds no slot
  logic tx_done; // Engine finished a message
  logic buf_pop; // RAM writer takes a word
  logic [1:0] vld_tmp; // Buffer valids after pop
  ram_word_s new_word; // Word built for the RAM
  logic [COUNT_W-1:0] count_tmp; // Count after this cycle

  // Advance a pointer with wrap at the programmed depth
  // Wrap point is the field, not a power of two
  function automatic logic [DEPTH_W-1:0] next_ptr(input logic [DEPTH_W-1:0] p,
                                                  input logic [DEPTH_W-1:0] last);
    logic [DEPTH_W-1:0] r;
    r = (p == last) ? '0 : p + 1'b1;
    return r;
  endfunction : next_ptr

  // ----------------------------------------------------------------
  // Level flags and read images
  // ----------------------------------------------------------------

  // Depth from the field, one to thirty-two slots
  // One bit wider than the field, so 32 slots fit
  // Half marks compare twice the count with the depth
  // Odd depths stay exact without a divider
  assign depth = {1'b0, s_reg.depth_m1} + 6'h01;
  assign is_empty = (s_reg.count == 6'h00);
  assign is_full = (s_reg.count == depth);
  assign half_low = ({s_reg.count, 1'b0} <= {1'b0, depth});
  assign half_high = ({s_reg.count, 1'b0} >= {1'b0, depth});

  // Visible flags, meaning depends on direction
  always_comb begin
    flags = '0;
    // Exhausted only seen in transmit direction
    flags[4] = s_reg.dir_tx & s_reg.exhausted;
    // Overflow only seen in receive direction
    flags[3] = ~s_reg.dir_tx & s_reg.overflow;
    if (s_reg.dir_tx) begin
      // Transmit: empty, half empty, not full
      flags[2] = is_empty;
      flags[1] = half_low;
      flags[0] = ~is_full;
    end else begin
      // Receive: full, half full, not empty
      flags[2] = is_full;
      flags[1] = half_high;
      flags[0] = ~is_empty;
    end
  end

  // Control word image; unlisted bits read zero
  always_comb begin
    control_word = '0;
    control_word[CTL_DEPTH_LSB +: DEPTH_W] = s_reg.depth_m1;
    control_word[CTL_RESET_BIT] = s_reg.reset_req;
    control_word[CTL_SEND_BIT] = s_reg.send_req;
    control_word[CTL_DIR_BIT] = s_reg.dir_tx;
    control_word[CTL_RTR_BIT] = s_reg.rtr_en;
    control_word[CTL_TS_BIT] = s_reg.ts_en;
    control_word[CTL_IE_LSB +: IE_W] = s_reg.ie;
  end

  // Status word image; index follows the direction
  always_comb begin
    status_word = '0;
    // Next slot to send, or next slot to fill
    status_word[STA_INDEX_LSB +: DEPTH_W] = s_reg.dir_tx ? s_reg.tail : s_reg.head;
    status_word[STA_ABT_BIT] = s_reg.aborted;
    status_word[STA_LARB_BIT] = s_reg.lost_arb;
    status_word[STA_ERR_BIT] = s_reg.bus_err;
    status_word[STA_FLAG_LSB +: IE_W] = flags;
  end

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------

  // Write strobes per word and lane
  assign wr_ctl = reg_req.wr & (reg_req.sel == REG_SEL_CONTROL);
  assign wr_sta = reg_req.wr & (reg_req.sel == REG_SEL_STATUS);
  assign cmd_lane = wr_ctl & reg_req.wstrb[LANE_CMD];
  assign low_lane = reg_req.wstrb[LANE_LOW];
  assign adv = cmd_lane & reg_req.wdata[CTL_ADV_BIT];

  // Send request writes act only in transmit direction
  assign sw_set = cmd_lane & reg_req.wdata[CTL_SEND_BIT] & s_reg.dir_tx;
  assign sw_abort = cmd_lane & ~reg_req.wdata[CTL_SEND_BIT] & s_reg.dir_tx
                    & s_reg.send_req;
  assign rtr_set = tx_ev.rtr & s_reg.rtr_en & s_reg.dir_tx;

  // Pointer moves, guarded against over- and underrun
  assign push_tx = adv & s_reg.dir_tx & ~is_full;
  assign pop_rx = adv & ~s_reg.dir_tx & ~is_empty;

  // Receive hand-over; no slot means overflow
  // Ready built from registers only, no loop via valid
  // Entry 1 must be free before a word is taken
  // Entry 0 may still wait on the RAM writer
  // Low during a pending reset, so no word is flushed
  assign rx_ready = ~s_reg.dir_tx & ~s_reg.reset_req & ~s_reg.buf_vld[1];
  assign rx_fire = rx_valid & rx_ready;
  assign rx_store = rx_fire & ~is_full;
  assign rx_lost = rx_fire & is_full;

  // Completed message only counts while one is in flight
  // Stray pulse must not walk the tail past the head
  assign tx_done = tx_ev.done & s_reg.dir_tx & (s_reg.phase != TX_IDLE) & ~is_empty;

  // Buffer drains while the RAM writer is ready
  assign buf_pop = s_reg.buf_vld[0] & ram_ready;

  // Word for the RAM writer, stamp only when enabled
  always_comb begin
    new_word = '0;
    new_word.slot = s_reg.head;
    new_word.store_ts = s_reg.ts_en;
    new_word.ts = s_reg.ts_en ? rx_timestamp : 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    vld_tmp = s_reg.buf_vld;
    count_tmp = s_reg.count;
    s_next.rvalid = 1'b0;

    // Register read, answered one cycle later
    // Read data holds until the next read
    if (reg_req.rd) begin
      s_next.rvalid = 1'b1;
      s_next.rdata = (reg_req.sel == REG_SEL_STATUS) ? status_word : control_word;
    end

    // Direction and stamp enable frozen outside configuration
    // Writes in normal mode are dropped silently
    if (wr_ctl && low_lane && config_mode) begin
      s_next.dir_tx = reg_req.wdata[CTL_DIR_BIT];
      s_next.ts_en = reg_req.wdata[CTL_TS_BIT];
    end
    // Depth also changes in configuration only
    if (cmd_lane == 1'b0 && wr_ctl && reg_req.wstrb[LANE_DEPTH] && config_mode) begin
      s_next.depth_m1 = reg_req.wdata[CTL_DEPTH_LSB +: DEPTH_W];
    end else if (wr_ctl && reg_req.wstrb[LANE_DEPTH] && config_mode) begin
      s_next.depth_m1 = reg_req.wdata[CTL_DEPTH_LSB +: DEPTH_W];
    end
    // Reply enable and interrupt enables always writable
    if (wr_ctl && low_lane) begin
      s_next.rtr_en = reg_req.wdata[CTL_RTR_BIT];
      s_next.ie = reg_req.wdata[CTL_IE_LSB +: IE_W];
    end

    // Status write of zero clears sticky bits
    // Writing one keeps a bit unchanged
    // Software clears one flag without racing others
    if (wr_sta && low_lane) begin
      s_next.aborted = s_reg.aborted & reg_req.wdata[STA_ABT_BIT];
      s_next.lost_arb = s_reg.lost_arb & reg_req.wdata[STA_LARB_BIT];
      s_next.bus_err = s_reg.bus_err & reg_req.wdata[STA_ERR_BIT];
      s_next.exhausted = s_reg.exhausted & reg_req.wdata[STA_FLAG_LSB + 4];
      s_next.overflow = s_reg.overflow & reg_req.wdata[STA_FLAG_LSB + 3];
    end

    // New send request wipes the previous outcome
    if (sw_set || rtr_set) begin
      s_next.send_req = 1'b1;
      s_next.aborted = 1'b0;
      s_next.lost_arb = 1'b0;
      s_next.bus_err = 1'b0;
    end

    // Count moves at most one step each way per cycle
    // Head side: software commit or received message
    if (push_tx || rx_store) begin
      s_next.head = next_ptr(s_reg.head, s_reg.depth_m1);
      count_tmp = count_tmp + 6'h01;
    end
    // Tail side: software release or sent message
    if (pop_rx || tx_done) begin
      s_next.tail = next_ptr(s_reg.tail, s_reg.depth_m1);
      count_tmp = count_tmp - 6'h01;
    end
    s_next.count = count_tmp;

    // Hardware sets win over software clears
    // Event in the cycle of a clear is never lost
    if (rx_lost) begin
      s_next.overflow = 1'b1;
    end
    if (tx_ev.exhausted && s_reg.dir_tx) begin
      s_next.exhausted = 1'b1;
    end

    // Transmit hand-off phase
    // Active while the engine may send the tail slot
    // Abort phase waits for the engine to answer
    unique case (s_reg.phase)
      TX_IDLE: begin
        // Zero over a waiting request withdraws it
        // Nothing on the bus yet, so no abort needed
        if (sw_abort) begin
          s_next.send_req = 1'b0;
        end
        // Start once a request meets a queued message
        if (s_next.send_req && (count_tmp != 6'h00)) begin
          s_next.phase = TX_ACTIVE;
        end
      end
      TX_ACTIVE: begin
        // Outcome of the running attempt
        if (tx_ev.lost_arb) begin
          s_next.lost_arb = 1'b1;
        end
        if (tx_ev.bus_err) begin
          s_next.bus_err = 1'b1;
        end
        if (tx_ev.aborted) begin
          // Engine gave the message up
          s_next.aborted = 1'b1;
          s_next.send_req = sw_set | rtr_set;
          s_next.phase = TX_IDLE;
        end else if (sw_abort) begin
          // Software pulled the request back
          s_next.send_req = 1'b0;
          s_next.phase = TX_ABORT;
        end else if (tx_done) begin
          s_next.aborted = 1'b0;
          // Request ends once the queue runs dry
          if (count_tmp == 6'h00) begin
            s_next.send_req = sw_set | rtr_set;
            s_next.phase = TX_IDLE;
          end
        end
      end
      TX_ABORT: begin
        // Wait for the engine to confirm
        // No new start until the slot is settled
        if (tx_ev.aborted) begin
          s_next.aborted = 1'b1;
          s_next.phase = TX_IDLE;
        end else if (tx_done) begin
          // Message won the race and went out
          s_next.aborted = 1'b0;
          s_next.phase = TX_IDLE;
        end
      end
      default: begin
        // Illegal code falls back to idle
        s_next.phase = TX_IDLE;
      end
    endcase

    // Two-entry buffer toward the RAM writer
    // Writer stall never drops a word, only lowers ready
    // Entry 1 moves down on a pop
    // New words fill the lowest free entry
    if (buf_pop) begin
      s_next.buf0 = s_reg.buf1;
      vld_tmp = {1'b0, s_reg.buf_vld[1]};
    end
    if (rx_store) begin
      if (!vld_tmp[0]) begin
        s_next.buf0 = new_word;
        vld_tmp[0] = 1'b1;
      end else begin
        s_next.buf1 = new_word;
        vld_tmp[1] = 1'b1;
      end
    end
    s_next.buf_vld = vld_tmp;

    // Pending reset empties the FIFO and clears its flags, then clears itself
    // Placed after the updates above so it beats them this cycle
    // Words still buffered for the RAM are dropped too
    if (s_reg.reset_req) begin
      s_next.head = '0;
      s_next.tail = '0;
      s_next.count = '0;
      s_next.buf_vld = '0;
      s_next.send_req = 1'b0;
      s_next.phase = TX_IDLE;
      s_next.aborted = 1'b0;
      s_next.lost_arb = 1'b0;
      s_next.bus_err = 1'b0;
      s_next.exhausted = 1'b0;
      s_next.overflow = 1'b0;
      s_next.reset_req = 1'b0;
    end
    // Software request or configuration mode keeps it set
    // After the clear, so a held request wins
    if ((cmd_lane && reg_req.wdata[CTL_RESET_BIT]) || config_mode) begin
      s_next.reset_req = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.reset_req <= RESET_REQ_RST;
      s_reg.depth_m1 <= DEPTH_RST;
      s_reg.phase <= TX_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = s_reg.rdata;
  assign reg_rvalid = s_reg.rvalid;
  assign ram_valid = s_reg.buf_vld[0];
  assign ram_word = s_reg.buf0;
  assign tx_pending = (s_reg.phase == TX_ACTIVE);
  assign tx_slot = s_reg.tail;
  assign abort_request = (s_reg.phase == TX_ABORT);
  // Any enabled flag raises the request
  // Built from registers only, so no glitch
  // Level request, stays up while the flag stands
  assign irq = |(flags & s_reg.ie);

endmodule : can_message_fifo_ctrl_status

// [pkg/fifo_ctrl_pkg.sv]
// Notes on behaviour
// - Reset request clears FIFO, then self-clears
// - Reset request held set in configuration mode
// - Send request clears after queue fully sent
// - Writing zero while sending requests abort
// - Receive FIFO ignores send request writes
// - Transmit advance moves head one slot
// - Receive advance moves tail one slot
// - Direction bit selects transmit or receive
// - Auto reply sets send request on remote
// - Time stamp stored only when enabled
// - Direction, stamp enable writable only in configuration
// - Enables gate exhausted and overflow interrupts
// - Three level enables, meaning set by direction
// - Index gives next transmit or fill slot
// - Outcome bits updated on completion, abort, reset
// - Outcome bits cleared by send or zero write
// - Exhausted flag in transmit, zero in receive
// - Overflow flag in receive, zero in transmit
// - Empty in transmit, full in receive
// - Half level flag, direction dependent comparison
// - Not full in transmit, not empty receive
// - Depth field holds depth minus one
package fifo_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register selection and byte lanes
  // ----------------------------------------------------------------
  localparam logic REG_SEL_CONTROL = 1'b0; // Control word
  localparam logic REG_SEL_STATUS = 1'b1; // Status word
  localparam int LANE_LOW = 0; // Bits 7:0
  localparam int LANE_CMD = 1; // Bits 15:8
  localparam int LANE_DEPTH = 3; // Bits 31:24

  // ----------------------------------------------------------------
  // Control word fields
  // ----------------------------------------------------------------
  localparam int CTL_RESET_BIT = 10;
  localparam int CTL_SEND_BIT = 9;
  localparam int CTL_ADV_BIT = 8;
  localparam int CTL_DIR_BIT = 7;
  localparam int CTL_RTR_BIT = 6;
  localparam int CTL_TS_BIT = 5;
  localparam int CTL_IE_LSB = 0; // Five enables, bits 4:0
  localparam int CTL_DEPTH_LSB = 24;
  localparam int DEPTH_W = 5;
  localparam int IE_W = 5;
  localparam int COUNT_W = 6;

  // ----------------------------------------------------------------
  // Status word fields
  // ----------------------------------------------------------------
  localparam int STA_INDEX_LSB = 8;
  localparam int STA_ABT_BIT = 7;
  localparam int STA_LARB_BIT = 6;
  localparam int STA_ERR_BIT = 5;
  localparam int STA_FLAG_LSB = 0; // Five flags, bits 4:0

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RESET_REQ_RST = 1'b1; // Reset request starts set
  localparam logic [DEPTH_W-1:0] DEPTH_RST = 5'h00;

  // Transmit engine hand-off phase
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_ACTIVE = 2'b01,
    TX_ABORT = 2'b10
  } tx_phase_e;

  // Register port request from the serial front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic sel;
    logic [3:0] wstrb;
    logic [31:0] wdata;
  } reg_req_s;

  // Word passed to the message RAM writer
  typedef struct packed {
    logic [DEPTH_W-1:0] slot;
    logic store_ts;
    logic [31:0] ts;
  } ram_word_s;

  // One-cycle event pulses from the protocol engine
  typedef struct packed {
    logic done;
    logic aborted;
    logic lost_arb;
    logic bus_err;
    logic exhausted;
    logic rtr;
  } tx_event_s;

  // All state of the controller
  typedef struct packed {
    logic reset_req;
    logic send_req;
    logic dir_tx;
    logic rtr_en;
    logic ts_en;
    logic [IE_W-1:0] ie;
    logic [DEPTH_W-1:0] depth_m1;
    logic aborted;
    logic lost_arb;
    logic bus_err;
    logic exhausted;
    logic overflow;
    logic [DEPTH_W-1:0] head;
    logic [DEPTH_W-1:0] tail;
    logic [COUNT_W-1:0] count;
    tx_phase_e phase;
    logic [1:0] buf_vld;
    ram_word_s buf0;
    ram_word_s buf1;
    logic [31:0] rdata;
    logic rvalid;
  } state_s;

endpackage : fifo_ctrl_pkg

// [dv/fifo_ctrl_asserts.sv]
`timescale 1ns/10ps
module fifo_ctrl_asserts (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic config_mode,
  input wire fifo_ctrl_pkg::reg_req_s reg_req,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [31:0] rx_timestamp,
  input wire logic ram_valid,
  input wire logic ram_ready,
  input wire fifo_ctrl_pkg::ram_word_s ram_word,
  input wire fifo_ctrl_pkg::tx_event_s tx_ev,
  input wire logic tx_pending,
  input wire logic [fifo_ctrl_pkg::DEPTH_W-1:0] tx_slot,
  input wire logic abort_request,
  input wire logic irq
);
  import fifo_ctrl_pkg::*;
  // ----------------------------------------
  // Port checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Control write that drops the send bit without a reset
  logic sw_abort;
  assign sw_abort = reg_req.wr && !reg_req.sel && reg_req.wstrb[LANE_CMD] &&
    !reg_req.wdata[CTL_SEND_BIT] && !reg_req.wdata[CTL_RESET_BIT];
  rx_tx_excl_a: assert property (rx_ready |-> !tx_pending)
    else $error("receive ready while sending");
  cfg_hold_a: assert property (config_mode && $past(config_mode)
    && $past(config_mode, 2) |-> !rx_ready && !tx_pending)
    else $error("fifo active in configuration mode");
  abort_req_a: assert property (tx_pending && sw_abort && tx_ev == '0 |=> abort_request)
    else $error("abort not requested");
  abort_cause_a: assert property ($rose(abort_request) |-> $past(tx_pending))
    else $error("abort without pending send");
  abort_end_a: assert property (abort_request && (tx_ev.aborted || tx_ev.done)
    && !reg_req.wr |=> !abort_request && !tx_pending)
    else $error("abort not closed");
  slot_step_a: assert property (tx_pending && tx_ev.done && !reg_req.wr
    |=> tx_slot == $past(tx_slot) + 5'h01 || tx_slot == 5'h00)
    else $error("slot did not advance");
  rd_answer_a: assert property (reg_req.rd |=> reg_rvalid ##1 (reg_rvalid == $past(reg_req.rd)))
    else $error("read answer timing");
  ram_hold_a: assert property (ram_valid && !ram_ready && !config_mode && !reg_req.wr
    && !$past(config_mode) && !$past(reg_req.wr) |=> ram_valid && $stable(ram_word))
    else $error("ram word not held");
  ts_zero_a: assert property (ram_valid && !ram_word.store_ts |-> ram_word.ts == 32'h0)
    else $error("stamp without enable");
  abort_c: cover property (abort_request && tx_ev.aborted);
  stall_c: cover property (ram_valid && !ram_ready);
  done_c: cover property (tx_pending && tx_ev.done);
endmodule : fifo_ctrl_asserts

bind can_message_fifo_ctrl_status fifo_ctrl_asserts u_chk (.clock(clock), .rst_n(rst_n),
  .config_mode(config_mode), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_timestamp(rx_timestamp), .ram_valid(ram_valid),
  .ram_ready(ram_ready), .ram_word(ram_word), .tx_ev(tx_ev), .tx_pending(tx_pending),
  .tx_slot(tx_slot), .abort_request(abort_request), .irq(irq));

// [dv/ram_sink.sv]
`timescale 1ns/10ps
module ram_sink (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic stall,
  output logic ram_ready
);
  // Message RAM writer with random back-pressure, moved on the falling edge
  always @(negedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ram_ready <= 1'b0;
    end else begin
      ram_ready <= !stall && ($urandom % 3 != 0);
    end
  end
endmodule : ram_sink

// [dv/can_message_fifo_ctrl_status_tb.sv]
`timescale 1ns/10ps
module can_message_fifo_ctrl_status_tb;
  import fifo_ctrl_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic config_mode = 1'b1;
  reg_req_s reg_req = '0;
  logic [31:0] reg_rdata;
  logic reg_rvalid;
  logic rx_valid = 1'b0;
  logic rx_ready;
  logic [31:0] rx_timestamp = 32'h0;
  logic ram_valid;
  logic ram_ready;
  ram_word_s ram_word;
  tx_event_s tx_ev = '0;
  logic tx_pending;
  logic [DEPTH_W-1:0] tx_slot;
  logic abort_request;
  logic irq;
  logic stall = 1'b1; // Receiver stall
  int n_fail = 0;
  int n_tests = 0;
  int cycles = 0;
  int cnt = 0; // Receive occupancy
  int head = 0; // Receive fill slot
  logic ts_on = 1'b1; // Stamping expected
  logic [31:0] q_rd[$]; // Expected read data
  ram_word_s q_ram[$]; // Expected RAM words

  always #50 clock = ~clock;

  can_message_fifo_ctrl_status u_dut (.clock(clock), .rst_n(rst_n), .config_mode(config_mode),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_timestamp(rx_timestamp), .ram_valid(ram_valid),
    .ram_ready(ram_ready), .ram_word(ram_word), .tx_ev(tx_ev), .tx_pending(tx_pending),
    .tx_slot(tx_slot), .abort_request(abort_request), .irq(irq));
  ram_sink u_sink (.clock(clock), .rst_n(rst_n), .stall(stall), .ram_ready(ram_ready));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  // One register write, one cycle wide
  task automatic wr(input logic sel, input logic [3:0] strb, input logic [31:0] data);
    @(negedge clock);
    reg_req = '{wr: 1'b1, rd: 1'b0, sel: sel, wstrb: strb, wdata: data};
    @(negedge clock);
    reg_req = '0;
  endtask : wr

  // One register read; the expectation goes to the queue
  task automatic rd(input logic sel, input logic [31:0] exp);
    @(negedge clock);
    reg_req = '{wr: 1'b0, rd: 1'b1, sel: sel, wstrb: 4'h0, wdata: 32'h0};
    q_rd.push_back(exp);
    @(negedge clock);
    reg_req = '0;
  endtask : rd

  // One-cycle engine pulse
  task automatic ev(input logic [5:0] e);
    @(negedge clock);
    tx_ev = tx_event_s'(e);
    @(negedge clock);
    tx_ev = '0;
  endtask : ev

  // Offer one received message until taken
  task automatic rx_send();
    @(negedge clock);
    rx_valid = 1'b1;
    rx_timestamp = $urandom;
    while (rx_ready !== 1'b1) @(negedge clock);
    if (cnt < 4) begin
      q_ram.push_back('{slot: head[4:0], store_ts: ts_on, ts: ts_on ? rx_timestamp : 32'h0});
      head = (head + 1) % 4;
      cnt++;
    end
    @(negedge clock);
    rx_valid = 1'b0;
  endtask : rx_send

  // Expected status word for a four-deep FIFO
  function automatic logic [31:0] sta(input logic tx, input logic [2:0] oc, input logic e,
      input int c, input int idx);
    logic [4:0] f;
    f = tx ? {e, 1'b0, c == 0, c <= 2, c < 4} : {1'b0, e, c == 4, c >= 2, c != 0};
    return {19'h0, idx[4:0], oc, f};
  endfunction : sta

  // ----------------------------------------
  // Output monitor and watchdog
  // ----------------------------------------
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      n_fail++;
      report_and_stop();
    end
    if (reg_rvalid === 1'b1) begin
      if (q_rd.size() == 0) check("read count", 1, 0);
      else check("read data", reg_rdata, q_rd.pop_front());
    end
    if (ram_valid === 1'b1 && ram_ready === 1'b1) begin
      if (q_ram.size() == 0) check("ram count", 1, 0);
      else check("ram word", ram_word, q_ram.pop_front());
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h4c8a));
    repeat (3) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    rd(REG_SEL_CONTROL, 32'h0000_0400);
    wr(REG_SEL_CONTROL, 4'h9, 32'h0300_00df);
    config_mode = 1'b0;
    repeat (2) @(negedge clock);
    rd(REG_SEL_CONTROL, 32'h0300_00df);
    wr(REG_SEL_CONTROL, 4'h9, 32'h0000_007f);
    rd(REG_SEL_CONTROL, 32'h0300_00df);
    rd(REG_SEL_STATUS, sta(1'b1, 3'h0, 1'b0, 0, 0));
    check("irq", irq, 1'b1);
    // Fill the transmit side past full
    for (int k = 1; k <= 5; k++) begin
      wr(REG_SEL_CONTROL, 4'h2, 32'h0000_0100);
      rd(REG_SEL_STATUS, sta(1'b1, 3'h0, 1'b0, (k > 4) ? 4 : k, 0));
    end
    check("irq", irq, 1'b0);
    wr(REG_SEL_CONTROL, 4'h2, 32'h0000_0200);
    check("pending", tx_pending, 1'b1);
    for (int k = 1; k <= 4; k++) begin
      ev(6'h20);
      check("slot", tx_slot, k % 4);
    end
    check("pending", tx_pending, 1'b0);
    rd(REG_SEL_CONTROL, 32'h0300_00df);
    rd(REG_SEL_STATUS, sta(1'b1, 3'h0, 1'b0, 0, 0));
    // Abort with outcome bits, then clear them
    wr(REG_SEL_CONTROL, 4'h2, 32'h0000_0100);
    wr(REG_SEL_CONTROL, 4'h2, 32'h0000_0200);
    ev(6'h0e);
    wr(REG_SEL_CONTROL, 4'h2, 32'h0000_0000);
    check("abort", abort_request, 1'b1);
    ev(6'h10);
    check("abort", abort_request, 1'b0);
    rd(REG_SEL_STATUS, sta(1'b1, 3'h7, 1'b1, 1, 0));
    wr(REG_SEL_CONTROL, 4'h2, 32'h0000_0200);
    rd(REG_SEL_STATUS, sta(1'b1, 3'h0, 1'b1, 1, 0));
    wr(REG_SEL_STATUS, 4'h1, 32'h0000_0000);
    rd(REG_SEL_STATUS, sta(1'b1, 3'h0, 1'b0, 1, 0));
    ev(6'h20);
    // Remote request with and without auto reply
    wr(REG_SEL_CONTROL, 4'h2, 32'h0000_0100);
    ev(6'h01);
    check("pending", tx_pending, 1'b1);
    ev(6'h20);
    wr(REG_SEL_CONTROL, 4'h1, 32'h0000_001f);
    wr(REG_SEL_CONTROL, 4'h2, 32'h0000_0100);
    ev(6'h01);
    check("pending", tx_pending, 1'b0);
    wr(REG_SEL_CONTROL, 4'h2, 32'h0000_0400);
    repeat (2) @(negedge clock);
    rd(REG_SEL_CONTROL, 32'h0300_009f);
    rd(REG_SEL_STATUS, sta(1'b1, 3'h0, 1'b0, 0, 0));
    // Receive direction with time stamps
    config_mode = 1'b1;
    wr(REG_SEL_CONTROL, 4'h9, 32'h0300_003f);
    config_mode = 1'b0;
    repeat (2) @(negedge clock);
    wr(REG_SEL_CONTROL, 4'h2, 32'h0000_0200);
    check("pending", tx_pending, 1'b0);
    rd(REG_SEL_CONTROL, 32'h0300_003f);
    fork
      begin
        repeat (20) @(negedge clock);
        stall = 1'b0;
      end
      repeat (6) rx_send();
    join
    while (q_ram.size() != 0) @(negedge clock);
    rd(REG_SEL_STATUS, sta(1'b0, 3'h0, 1'b1, 4, 0));
    wr(REG_SEL_CONTROL, 4'h2, 32'h0000_0100);
    cnt--;
    rd(REG_SEL_STATUS, sta(1'b0, 3'h0, 1'b1, 3, 0));
    rx_send();
    while (q_ram.size() != 0) @(negedge clock);
    rd(REG_SEL_STATUS, sta(1'b0, 3'h0, 1'b1, 4, 1));
    // Stamping off: the word carries no time stamp
    config_mode = 1'b1;
    wr(REG_SEL_CONTROL, 4'h1, 32'h0000_001f);
    config_mode = 1'b0;
    ts_on = 1'b0;
    cnt = 0;
    head = 0;
    repeat (2) @(negedge clock);
    rx_send();
    while (q_ram.size() != 0) @(negedge clock);
    rd(REG_SEL_STATUS, sta(1'b0, 3'h0, 1'b0, 1, 1));
    check("irq", irq, 1'b1);
    repeat (3) @(negedge clock);
    report_and_stop();
  end
endmodule : can_message_fifo_ctrl_status_tb
